// >>> dac_load_pkg.sv
// constants shared by the quad converter serial load control block
package dac_load_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int WORD_BITS = 32;
    localparam int CHANNELS = 4;
    localparam int CODE_BITS = 16;
    localparam int CNT_BITS = 6;
    localparam int ADDR_W = 8;
    localparam int SYNC_BITS = 6;
    localparam logic [CNT_BITS-1:0] FRAME_BITS = 6'h20;

    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_LAST_WORD = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_DAC_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_INPUT_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_STRIDE = 8'h04;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_DAISY_BIT = 0;
    localparam int CTRL_CLRSEL_LSB = 1;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_CNT_LSB = 8;
    localparam int STAT_CLEAR_BIT = 16;
    localparam int STAT_STROBE_BIT = 17;
    localparam int STAT_NEW_LSB = 20;
    localparam int WORD_CH_LSB = 20;
    localparam int WORD_DATA_LSB = 0;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic CTRL_DAISY_RESET = 1'b0;
    localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
    localparam logic [1:0] CLR_SEL_MID = 2'h1;
    localparam logic [1:0] CLR_SEL_FULL = 2'h2;
    localparam logic [1:0] CLR_SEL_RESET = CLR_SEL_ZERO;
    localparam logic [CODE_BITS-1:0] CODE_ZERO = 16'h0000;
    localparam logic [CODE_BITS-1:0] CODE_MID = 16'h8000;
    localparam logic [CODE_BITS-1:0] CODE_FULL = 16'hffff;
    // pin idle levels {serial clk, frame sel, data in, strobe, clear, level sel}
    localparam logic [SYNC_BITS-1:0] SYNC_RESET = 6'h36;
    // cycles after reset release before pin edges are trusted
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    localparam logic [1:0] INIT_LOAD = 2'h1;

endpackage : dac_load_pkg

// >>> pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ************************************************************
    // one two-stage chain per bit
    // ************************************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // first stage is read only by the second stage
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                meta_q[i] <= RESET_VALUE[i];
                sync_q[i] <= RESET_VALUE[i];
            end else begin
                meta_q[i] <= pin_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign pin_sync_out = sync_q;

endmodule : pin_sync

// >>> quad_dac_serial_load_control.sv
// serial load, strobe, clear and power-up control of a quad converter
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module quad_dac_serial_load_control #(
    parameter int CHANNELS = dac_load_pkg::CHANNELS,
    parameter int CODE_BITS = dac_load_pkg::CODE_BITS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [dac_load_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // serial link pins
    input wire logic serial_clk,
    input wire logic frame_sel_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // strobe and level pins
    input wire logic load_dac_strobe_n,
    input wire logic async_clear_n,
    input wire logic reset_level_sel,
    // converter codes
    output logic [CHANNELS-1:0][CODE_BITS-1:0] dac_code
);
    import dac_load_pkg::*;

    localparam int CH_BITS = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

    typedef enum logic [1:0] {FRAME_IDLE, FRAME_SHIFT, FRAME_FULL} frame_state_type;

    // ************************************************************
    // pin synchronisation and edge detection
    // ************************************************************
    logic sclk_s, fsel_s, din_s, strobe_s, clr_s, level_s;
    logic sclk_q, fsel_q, strobe_q, clr_q;
    logic [1:0] init_q;
    logic init_done, por_load;
    logic sclk_fall, sclk_rise, frame_fall, frame_rise, strobe_fall, clr_fall;

    pin_sync #(
        .WIDTH(SYNC_BITS),
        .RESET_VALUE(SYNC_RESET)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in({serial_clk, frame_sel_n, serial_data_in, load_dac_strobe_n, async_clear_n,
                 reset_level_sel}),
        .pin_sync_out({sclk_s, fsel_s, din_s, strobe_s, clr_s, level_s})
    );

    // previous levels of the synchronised pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_q <= SYNC_RESET[5];
            fsel_q <= SYNC_RESET[4];
            strobe_q <= SYNC_RESET[2];
            clr_q <= SYNC_RESET[1];
        end else begin
            sclk_q <= sclk_s;
            fsel_q <= fsel_s;
            strobe_q <= strobe_s;
            clr_q <= clr_s;
        end
    end

    // settle counter: pins are trusted only once the chains hold real levels
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            init_q <= INIT_CYCLES;
        end else if (!init_done) begin
            init_q <= init_q - 2'h1;
        end
    end

    assign init_done = (init_q == 2'h0);
    assign por_load = (init_q == INIT_LOAD);

    // edges of the link and strobe pins
    assign sclk_fall = init_done & sclk_q & ~sclk_s;
    assign sclk_rise = init_done & ~sclk_q & sclk_s;
    assign frame_fall = init_done & fsel_q & ~fsel_s;
    assign frame_rise = init_done & ~fsel_q & fsel_s;
    assign strobe_fall = init_done & strobe_q & ~strobe_s;
    assign clr_fall = init_done & clr_q & ~clr_s;

    // ************************************************************
    // control register
    // ************************************************************
    logic daisy_q;
    logic [1:0] clr_sel_q;
    logic [CODE_BITS-1:0] clear_value;

    // software writes the chain mode and the clear-code setting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            daisy_q <= CTRL_DAISY_RESET;
            clr_sel_q <= CLR_SEL_RESET;
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            daisy_q <= reg_wdata[CTRL_DAISY_BIT];
            clr_sel_q <= reg_wdata[CTRL_CLRSEL_LSB +: 2];
        end
    end

    // code loaded by a clear
    always_comb begin
        case (clr_sel_q)
            CLR_SEL_MID: clear_value = CODE_MID[CODE_BITS-1:0];
            CLR_SEL_FULL: clear_value = CODE_FULL[CODE_BITS-1:0];
            default: clear_value = CODE_ZERO[CODE_BITS-1:0];
        endcase
    end

    // ************************************************************
    // serial frame
    // ************************************************************
    frame_state_type state_q;
    logic [CNT_BITS-1:0] bit_cnt_q;
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] last_word_q;
    logic [WORD_BITS-1:0] word_d;
    logic shift_en, last_fall, word_fire, sdo_q;
    logic [CH_BITS-1:0] fire_ch;
    logic [CODE_BITS-1:0] fire_data;

    // a fall that coincides with an abort is not taken
    assign shift_en = sclk_fall & (state_q == FRAME_SHIFT) & ~frame_rise & ~frame_fall;
    assign last_fall = shift_en & (bit_cnt_q == FRAME_BITS - 6'h1);
    // standalone acts on the 32nd fall, a chain on the frame end
    assign word_fire = daisy_q ? (frame_rise & (state_q == FRAME_SHIFT) &
                                  (bit_cnt_q == FRAME_BITS)) : last_fall;
    assign word_d = daisy_q ? shift_q : {shift_q[WORD_BITS-2:0], din_s};
    assign fire_ch = word_d[WORD_CH_LSB +: CH_BITS];
    assign fire_data = word_d[WORD_DATA_LSB +: CODE_BITS];

    // frame state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= FRAME_IDLE;
        end else if (frame_rise) begin
            state_q <= FRAME_IDLE;
        end else if (frame_fall) begin
            state_q <= FRAME_SHIFT;
        end else begin
            case (state_q)
                FRAME_SHIFT: begin
                    if (last_fall && !daisy_q) begin
                        state_q <= FRAME_FULL;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // bit counter, saturating at one word
    always_ff @(posedge clk_sys) begin
        if (rst || frame_fall) begin
            bit_cnt_q <= '0;
        end else if (shift_en && bit_cnt_q != FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 6'h1;
        end
    end

    // shift register takes one data bit per falling edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shift_q <= '0;
        end else if (shift_en) begin
            shift_q <= {shift_q[WORD_BITS-2:0], din_s};
        end
    end

    // last accepted word, readable by software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_word_q <= '0;
        end else if (word_fire) begin
            last_word_q <= word_d;
        end
    end

    // chain output moves on rising edges so the next part samples on falls
    always_ff @(posedge clk_sys) begin
        if (rst || !daisy_q) begin
            sdo_q <= 1'b0;
        end else if (sclk_rise) begin
            sdo_q <= shift_q[WORD_BITS-1];
        end
    end

    assign serial_data_out = sdo_q;

    // ************************************************************
    // input and DAC registers
    // ************************************************************
    logic [CODE_BITS-1:0] input_q [CHANNELS];
    logic [CODE_BITS-1:0] dac_q [CHANNELS];
    logic new_q [CHANNELS];
    logic strobe_pulse, direct;
    logic [CODE_BITS-1:0] por_value;

    assign strobe_pulse = strobe_fall & clr_s;
    assign direct = word_fire & ~strobe_s & clr_s;
    assign por_value = level_s ? CODE_MID[CODE_BITS-1:0] : CODE_ZERO[CODE_BITS-1:0];

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
        logic wr_ch;

        assign wr_ch = word_fire & (fire_ch == CH_BITS'(ch));

        // input register: a word in the same cycle as a clear wins
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                input_q[ch] <= CODE_ZERO[CODE_BITS-1:0];
            end else if (por_load) begin
                input_q[ch] <= por_value;
            end else if (wr_ch) begin
                input_q[ch] <= fire_data;
            end else if (clr_fall) begin
                input_q[ch] <= clear_value;
            end
        end

        // DAC register
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                dac_q[ch] <= CODE_ZERO[CODE_BITS-1:0];
            end else if (por_load) begin
                dac_q[ch] <= por_value;
            end else if (clr_fall) begin
                dac_q[ch] <= clear_value;
            end else if (direct && wr_ch) begin
                dac_q[ch] <= fire_data;
            end else if (strobe_pulse && new_q[ch]) begin
                dac_q[ch] <= input_q[ch];
            end
        end

        // new-data flag: a word with clear low still sets it, a direct word (also one with a strobe fall) clears it
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                new_q[ch] <= 1'b0;
            end else if (wr_ch && !direct) begin
                new_q[ch] <= 1'b1;
            end else if (strobe_pulse || clr_fall || por_load || wr_ch) begin
                new_q[ch] <= 1'b0;
            end
        end

        assign dac_code[ch] = dac_q[ch];
    end

    // ************************************************************
    // register read port
    // ************************************************************
    logic [31:0] rd_d;

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_d = '0;
        if (reg_addr == ADDR_CTRL) begin
            rd_d[CTRL_DAISY_BIT] = daisy_q;
            rd_d[CTRL_CLRSEL_LSB +: 2] = clr_sel_q;
        end else if (reg_addr == ADDR_STATUS) begin
            rd_d[STAT_ACTIVE_BIT] = (state_q != FRAME_IDLE);
            rd_d[STAT_FULL_BIT] = (state_q == FRAME_FULL);
            rd_d[STAT_CNT_LSB +: CNT_BITS] = bit_cnt_q;
            rd_d[STAT_CLEAR_BIT] = clr_s;
            rd_d[STAT_STROBE_BIT] = strobe_s;
            for (int i = 0; i < CHANNELS; i++) begin
                rd_d[STAT_NEW_LSB + i] = new_q[i];
            end
        end else if (reg_addr == ADDR_LAST_WORD) begin
            rd_d = last_word_q;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (reg_addr == ADDR_DAC_BASE + ADDR_W'(i) * ADDR_STRIDE) begin
                    rd_d[CODE_BITS-1:0] = dac_q[i];
                end
                if (reg_addr == ADDR_INPUT_BASE + ADDR_W'(i) * ADDR_STRIDE) begin
                    rd_d[CODE_BITS-1:0] = input_q[i];
                end
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst || !reg_rd) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rd_d;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_frame_start: assert property (@(posedge clk_sys) disable iff (rst)
        frame_fall && !frame_rise |=> state_q == FRAME_SHIFT && bit_cnt_q == 6'h0)
        else $error("frame did not start on frame select fall");
    a_bit_sample: assert property (@(posedge clk_sys) disable iff (rst)
        shift_en |=> shift_q[0] == $past(din_s) && shift_q[31:1] == $past(shift_q[30:0]))
        else $error("shift register did not take the data bit");
    a_word_at_32: assert property (@(posedge clk_sys) disable iff (rst)
        shift_en && bit_cnt_q == 6'h1f && !daisy_q |-> word_fire ##1 state_q == FRAME_FULL)
        else $error("full word not taken at the 32nd fall");
    a_abort_discard: assert property (@(posedge clk_sys) disable iff (rst)
        frame_rise && bit_cnt_q < FRAME_BITS |-> !word_fire ##1 state_q == FRAME_IDLE)
        else $error("partial frame was not discarded");
    a_extra_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == FRAME_FULL && !frame_fall |=> $stable(shift_q) && !$past(word_fire))
        else $error("edges after a full word changed the frame");

    a_strobe_copy: assert property (@(posedge clk_sys) disable iff (rst)
        strobe_pulse && new_q[0] && !clr_fall && !por_load && !(direct && fire_ch == '0)
        |=> dac_q[0] == $past(input_q[0]) && !new_q[0] || $past(word_fire))
        else $error("strobe did not copy new input data");
    a_clear_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        init_done && !clr_s && !clr_q |=> $stable(dac_q[0]) && $stable(dac_q[1]))
        else $error("DAC registers changed while clear held low");
    a_clear_load: assert property (@(posedge clk_sys) disable iff (rst)
        clr_fall |=> dac_q[0] == $past(clear_value) && dac_q[CHANNELS-1] == $past(clear_value))
        else $error("clear did not load the clear code");
    a_clear_default: assert property (@(posedge clk_sys)
        rst |=> clr_sel_q == CLR_SEL_ZERO && clear_value == CODE_ZERO)
        else $error("clear code not zero after reset");

    a_power_level: assert property (@(posedge clk_sys) disable iff (rst)
        por_load |=> dac_q[0] == ($past(level_s) ? CODE_MID : CODE_ZERO) ##2 init_done)
        else $error("power-up code does not follow the level select");
    a_direct_update: assert property (@(posedge clk_sys) disable iff (rst)
        direct && fire_ch == '0 |=> dac_q[0] == $past(fire_data) && !new_q[0])
        else $error("held-low strobe did not update the DAC at once");

    a_chain_rise: assert property (@(posedge clk_sys) disable iff (rst)
        sclk_rise && daisy_q && $past(daisy_q) |=> serial_data_out == $past(shift_q[31]))
        else $error("chain output not moved on the rising edge");

    c_full_frame: cover property (@(posedge clk_sys) disable iff (rst) word_fire && !daisy_q);
    c_abort: cover property (@(posedge clk_sys) disable iff (rst)
        frame_rise && state_q == FRAME_SHIFT && bit_cnt_q != FRAME_BITS);
    c_strobe_copy: cover property (@(posedge clk_sys) disable iff (rst) strobe_pulse && new_q[0]);
    c_clear: cover property (@(posedge clk_sys) disable iff (rst) clr_fall);
    c_chain_word: cover property (@(posedge clk_sys) disable iff (rst) word_fire && daisy_q);

endmodule : quad_dac_serial_load_control

// >>> dac_host_model.sv
// host side model: drives the serial link and samples the chain output
`timescale 1ns/10ps
module dac_host_model (
    // pacing clock
    input wire logic clk_sys,
    // link pins
    output logic serial_clk,
    output logic frame_sel_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [31:0] cap_word;

    // ************************************************************
    // idle levels
    // ************************************************************
    initial begin
        serial_clk = 1'b1; // clock stands still high between frames
        frame_sel_n = 1'b1;
        serial_data_in = 1'b0;
        cap_word = 32'h0;
    end

    // one frame with nfall clock falls, msb first; fewer than 32 aborts it
    task automatic send_word(input logic [31:0] word, input int nfall);
        @(posedge clk_sys);
        frame_sel_n <= 1'b0;
        for (int i = 0; i < nfall; i++) begin
            serial_data_in <= word[31 - (i % 32)];
            repeat (4) @(posedge clk_sys);
            @(negedge clk_sys);
            cap_word = {cap_word[30:0], serial_data_out}; // sampled before each fall
            @(posedge clk_sys);
            serial_clk <= 1'b0;
            repeat (3) @(posedge clk_sys);
            serial_clk <= 1'b1;
        end
        repeat (4) @(posedge clk_sys);
        frame_sel_n <= 1'b1;
        serial_data_in <= ~serial_data_in; // released line must not keep its value
        repeat (8) @(posedge clk_sys);
    endtask : send_word
endmodule : dac_host_model

// >>> test_quad_dac_serial_load_control.sv
// self-checking bench of the quad converter serial load control block
`timescale 1ns/10ps
module test_quad_dac_serial_load_control;
    import dac_load_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic serial_clk, frame_sel_n, serial_data_in, serial_data_out;
    logic load_dac_strobe_n = 1'b1;
    logic async_clear_n = 1'b1;
    logic reset_level_sel = 1'b1;
    logic [CHANNELS-1:0][CODE_BITS-1:0] dac_code;
    logic [31:0] rd_val;
    logic [CODE_BITS-1:0] clr_tab [3] = '{CODE_ZERO, CODE_MID, CODE_FULL};
    int error_cnt = 0;
    int cmp_count = 0;

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    quad_dac_serial_load_control u_quad_dac_serial_load_control (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clk(serial_clk),
        .frame_sel_n(frame_sel_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .load_dac_strobe_n(load_dac_strobe_n),
        .async_clear_n(async_clear_n), .reset_level_sel(reset_level_sel), .dac_code(dac_code)
    );

    dac_host_model u_dac_host_model (
        .clk_sys(clk_sys), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [ADDR_W-1:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [ADDR_W-1:0] addr);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd_val = reg_rdata;
    endtask : reg_read

    task automatic strobe_pulse;
        @(posedge clk_sys);
        load_dac_strobe_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        load_dac_strobe_n <= 1'b1; // pulsed and returned high
        repeat (6) @(posedge clk_sys);
    endtask : strobe_pulse

    task automatic set_clear(input logic lvl);
        @(posedge clk_sys);
        async_clear_n <= lvl;
        repeat (6) @(posedge clk_sys);
    endtask : set_clear

    // reset held two cycles, link idle for six more
    task automatic do_reset(input logic lvl);
        @(posedge clk_sys);
        rst <= 1'b1;
        reset_level_sel <= lvl;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : do_reset

    function automatic logic [31:0] mk(input int ch, input logic [15:0] code);
        return (32'(ch) << WORD_CH_LSB) | 32'(code);
    endfunction : mk

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_power;
        do_reset(1'b1);
        for (int ch = 0; ch < CHANNELS; ch++) check(32'(dac_code[ch]), 32'(CODE_MID));
        reg_read(ADDR_INPUT_BASE + 8'h04);
        check(rd_val, 32'(CODE_MID));
        do_reset(1'b0);
        for (int ch = 0; ch < CHANNELS; ch++) check(32'(dac_code[ch]), 32'(CODE_ZERO));
        reg_read(ADDR_CTRL);
        check(rd_val, 32'h0);
        reg_read(8'h40);
        check(rd_val, 32'h0);
    endtask : t_power

    // strobe held low: words act at once, extra falls ignored, short frame dropped
    task automatic t_direct;
        @(posedge clk_sys);
        load_dac_strobe_n <= 1'b0;
        u_dac_host_model.send_word(mk(2, 16'h1234), 32);
        check(32'(dac_code[2]), 32'h1234);
        u_dac_host_model.send_word(mk(1, 16'habcd), 34);
        check(32'(dac_code[1]), 32'habcd);
        u_dac_host_model.send_word(mk(0, 16'h5555), 31);
        check(32'(dac_code[0]), 32'h0);
        reg_read(ADDR_INPUT_BASE);
        check(rd_val, 32'h0);
        u_dac_host_model.send_word(mk(0, 16'h5555), 32);
        check(32'(dac_code[0]), 32'h5555);
    endtask : t_direct

    task automatic t_strobe;
        @(posedge clk_sys);
        load_dac_strobe_n <= 1'b1;
        u_dac_host_model.send_word(mk(3, 16'h0f0f), 32);
        check(32'(dac_code[3]), 32'h0);
        reg_read(ADDR_INPUT_BASE + 8'h0c);
        check(rd_val, 32'h0f0f);
        strobe_pulse();
        check(32'(dac_code[3]), 32'h0f0f);
        check(32'(dac_code[2]), 32'h1234);
    endtask : t_strobe

    // every clear code, and strobe ignored while clear is low
    task automatic t_clear;
        for (int k = 0; k < 3; k++) begin
            reg_write(ADDR_CTRL, 32'(k) << CTRL_CLRSEL_LSB);
            u_dac_host_model.send_word(mk(0, 16'h1111), 32);
            set_clear(1'b0);
            check(32'(dac_code[0]), 32'(clr_tab[k]));
            check(32'(dac_code[3]), 32'(clr_tab[k]));
            reg_read(ADDR_INPUT_BASE);
            check(rd_val, 32'(clr_tab[k]));
            u_dac_host_model.send_word(mk(1, 16'h2222), 32);
            strobe_pulse();
            check(32'(dac_code[1]), 32'(clr_tab[k]));
            set_clear(1'b1);
            strobe_pulse();
            check(32'(dac_code[1]), 32'h2222);
        end
    endtask : t_clear

    task automatic t_daisy;
        reg_write(ADDR_CTRL, 32'h1);
        u_dac_host_model.send_word(mk(2, 16'hbeef), 32);
        u_dac_host_model.send_word(mk(0, 16'h0123), 32);
        check(u_dac_host_model.cap_word, mk(2, 16'hbeef));
        strobe_pulse();
        check(32'(dac_code[2]), 32'hbeef);
        check(32'(dac_code[0]), 32'h0123);
    endtask : t_daisy

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // main sequence
    initial begin
        t_power();
        t_direct();
        t_strobe();
        t_clear();
        t_daisy();
        print_verdict();
    end

    // watchdog, about ten times the expected run
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule : test_quad_dac_serial_load_control
